// File: otp_program_memory_access.sv
`timescale 1ns/1ps
module otp_program_memory_access #(
   parameter int PULSE_CYCLES = otp_pkg::PULSE_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic test_vpp,
   input wire logic reset_pin_n,
   input wire logic mode_qualifier_line,
   input wire logic prog_mode_control,
   input wire logic top_address_bit,
   input wire otp_pkg::strobes_t strobes,
   input wire logic [7:0] shared_port_bus_in,
   output logic [7:0] shared_port_bus_out,
   output logic shared_port_bus_oe,
   input wire otp_pkg::cpu_rd_t cpu_rd,
   output logic [7:0] cpu_rd_data,
   output logic cpu_rd_hit,
   output logic prog_mode,
   output logic secured
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PULSE = 2'b01,
      ST_DONE = 2'b10
   } pst_t;

   function automatic logic run_hit(input logic [15:0] a);
      return a >= otp_pkg::RUN_BASE;
   endfunction : run_hit

   // Address latch, program pulse timer, security and output state
   logic [7:0] addr_hi_q, addr_hi_d, addr_lo_q, addr_lo_d;
   logic prog_mode_q, prog_mode_d, secured_q, secured_d;
   logic [7:0] bus_out_q, bus_out_d;
   logic bus_oe_q, bus_oe_d, hit_q, hit_d, rd_pend_q, rd_pend_d;
   logic [7:0] cpu_data_q, cpu_data_d;
   pst_t pst_q, pst_d;
   logic [31:0] cnt_q, cnt_d;
   logic wr_en;
   logic [16:0] full_addr;
   logic in_array, at_secure;
   logic [10:0] rd_addr;
   logic [7:0] rd_data;

   logic latch_phase, pulse_start, arm_secure;

   assign full_addr = {top_address_bit, addr_hi_q, addr_lo_q};
   assign in_array = full_addr <= otp_pkg::PROM_LAST;
   assign at_secure = full_addr == otp_pkg::SECURE_ADDR;
   assign latch_phase = prog_mode_q && strobes.ce_n && strobes.oe_n;
   assign pulse_start = prog_mode_q && !strobes.ce_n && !strobes.pgm_n && strobes.oe_n;

   // Mode pins are taken as synchronous, so one register stage is enough
   always_comb begin
      prog_mode_d = test_vpp && !reset_pin_n && mode_qualifier_line;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prog_mode_q <= 1'b0;
      end else begin
         prog_mode_q <= prog_mode_d;
      end
   end

   // Address phases: prog_mode_control high takes the high byte, low the low byte
   always_comb begin
      addr_hi_d = addr_hi_q;
      addr_lo_d = addr_lo_q;
      if (latch_phase) begin
         if (prog_mode_control) begin
            addr_hi_d = shared_port_bus_in;
         end else begin
            addr_lo_d = shared_port_bus_in;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         addr_hi_q <= 8'h00;
         addr_lo_q <= 8'h00;
      end else begin
         addr_hi_q <= addr_hi_d;
         addr_lo_q <= addr_lo_d;
      end
   end

   // Write fires once per pulse, at its falling edge; a strobe held low longer
   // than the pulse time never stacks a second write
   always_comb begin
      pst_d = pst_q;
      cnt_d = cnt_q;
      wr_en = 1'b0;
      arm_secure = 1'b0;
      case (pst_q)
         ST_IDLE: begin
            if (pulse_start) begin
               pst_d = ST_PULSE;
               cnt_d = 32'd0;
               if (in_array) begin
                  wr_en = 1'b1;
               end else if (at_secure && !shared_port_bus_in[otp_pkg::SECURE_BIT]) begin
                  arm_secure = 1'b1;
               end
            end
         end
         ST_PULSE: begin
            cnt_d = cnt_q + 32'd1;
            if (strobes.pgm_n) begin
               pst_d = ST_IDLE;
            end else if (cnt_q >= 32'(PULSE_CYCLES)) begin
               pst_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (strobes.pgm_n) begin
               pst_d = ST_IDLE;
            end
         end
         default: begin
            pst_d = ST_IDLE;
         end
      endcase
      if (!prog_mode_q) begin
         pst_d = ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pst_q <= ST_IDLE;
         cnt_q <= 32'd0;
      end else begin
         pst_q <= pst_d;
         cnt_q <= cnt_d;
      end
   end

   // Set only, like the fuse it models; nothing but rst clears it
   always_comb begin
      secured_d = secured_q || arm_secure;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         secured_q <= 1'b0;
      end else begin
         secured_q <= secured_d;
      end
   end

   // The array read port is shared: programming mode owns it, so a run-mode
   // read made then is never answered
   assign rd_addr = prog_mode_q ? full_addr[10:0] : cpu_rd.addr[10:0];

   always_comb begin
      bus_oe_d = prog_mode_q && !strobes.ce_n && !strobes.oe_n;
      if (secured_q || !in_array) begin
         bus_out_d = otp_pkg::ERASED;
      end else begin
         bus_out_d = rd_data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_out_q <= otp_pkg::ERASED;
         bus_oe_q <= 1'b0;
      end else begin
         bus_out_q <= bus_out_d;
         bus_oe_q <= bus_oe_d;
      end
   end

   always_comb begin
      rd_pend_d = !prog_mode_q && cpu_rd.req && run_hit(cpu_rd.addr);
      hit_d = rd_pend_q;
      cpu_data_d = rd_pend_q ? rd_data : cpu_data_q;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_pend_q <= 1'b0;
         hit_q <= 1'b0;
         cpu_data_q <= otp_pkg::ERASED;
      end else begin
         rd_pend_q <= rd_pend_d;
         hit_q <= hit_d;
         cpu_data_q <= cpu_data_d;
      end
   end

   otp_array #(.AW(otp_pkg::ADDR_W), .DEPTH(otp_pkg::MEM_DEPTH)) u_array (
      .ref_clk(ref_clk),
      .wr_en(wr_en),
      .wr_addr(full_addr[10:0]),
      .wr_data(shared_port_bus_in),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   assign shared_port_bus_out = bus_out_q;
   assign shared_port_bus_oe = bus_oe_q;
   assign cpu_rd_data = cpu_data_q;
   assign cpu_rd_hit = hit_q;
   assign prog_mode = prog_mode_q;
   assign secured = secured_q;
endmodule : otp_program_memory_access

// File: otp_pkg.sv
package otp_pkg;
   localparam int ADDR_W = 11;
   localparam int MEM_DEPTH = 2048;
   localparam logic [15:0] RUN_BASE = 16'hF800;
   localparam logic [15:0] RUN_LAST = 16'hFFFF;
   localparam logic [16:0] PROM_LAST = 17'h007FF;
   localparam logic [16:0] SECURE_ADDR = 17'h01101;
   localparam int SECURE_BIT = 0;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam int CLK_MHZ = 50;
   localparam int PULSE_NS = 100000;
   localparam int PULSE_CYC = PULSE_NS * CLK_MHZ / 1000;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic pgm_n;
   } strobes_t;

   typedef struct packed {
      logic req;
      logic [15:0] addr;
   } cpu_rd_t;
endpackage : otp_pkg

// File: otp_array.sv
`timescale 1ns/1ps
module otp_array #(
   parameter int AW = 11,
   parameter int DEPTH = 2048
) (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [DEPTH];

   // One-time cells only clear bits: a write ANDs into the stored byte
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = 8'hFF;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= mem[wr_addr] & wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : otp_array

// File: otp_asserts.sv
`timescale 1ns/1ps
module otp_chk #(
   parameter int PULSE_CYCLES = otp_pkg::PULSE_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic test_vpp,
   input wire logic reset_pin_n,
   input wire logic mode_qualifier_line,
   input wire otp_pkg::strobes_t strobes,
   input wire logic [7:0] shared_port_bus_out,
   input wire logic shared_port_bus_oe,
   input wire otp_pkg::cpu_rd_t cpu_rd,
   input wire logic cpu_rd_hit,
   input wire logic prog_mode,
   input wire logic secured
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_mode_entry: assert property (
      test_vpp && !reset_pin_n && mode_qualifier_line |=> prog_mode) else $error("no entry");
   chk_mode_exit: assert property (
      !(test_vpp && !reset_pin_n && mode_qualifier_line) |=> !prog_mode)
      else $error("no exit");
   chk_oe_drop: assert property (
      !prog_mode || strobes.ce_n || strobes.oe_n |=> !shared_port_bus_oe)
      else $error("bus left driven");
   chk_run_hit: assert property (
      cpu_rd.req && !prog_mode && cpu_rd.addr >= otp_pkg::RUN_BASE |-> ##2 cpu_rd_hit)
      else $error("no hit");
   chk_no_hit: assert property (
      cpu_rd.req && (prog_mode || cpu_rd.addr < otp_pkg::RUN_BASE) |-> ##2 !cpu_rd_hit)
      else $error("stray hit");
   chk_hit_cause: assert property (
      cpu_rd_hit |-> $past(cpu_rd.req, 2)) else $error("hit without request");
   chk_oe_cause: assert property (
      shared_port_bus_oe |-> !$past(strobes.ce_n) && !$past(strobes.oe_n))
      else $error("bus driven");
   chk_oe_rise: assert property (
      prog_mode && !strobes.ce_n && !strobes.oe_n |-> ##[1:2] shared_port_bus_oe)
      else $error("bus not driven");
   chk_secure_arm: assert property (
      $rose(secured) |-> !$past(strobes.ce_n) && !$past(strobes.pgm_n) && $past(strobes.oe_n))
      else $error("armed late");
   chk_secure_ff: assert property (
      secured && shared_port_bus_oe |-> shared_port_bus_out == otp_pkg::ERASED)
      else $error("secured data shown");
endmodule : otp_chk
bind otp_program_memory_access otp_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// File: prom_prog.sv
`timescale 1ns/1ps
module prom_prog #(
   parameter int PULSE = 8
) (
   input wire logic ref_clk,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe,
   output logic [7:0] bus_in,
   output otp_pkg::strobes_t strb,
   output logic pmc,
   output logic a16
);
   logic [7:0] drv = 8'hA5;
   logic en = 1'b0;
   int pulses = 0;
   // Released bus shows the inverse, so a stale byte never passes
   assign bus_in = bus_oe ? bus_out : (en ? drv : ~drv);
   initial {strb, pmc, a16} = 5'h1E;
   // Only 0000-07FF, 0800, 1101 and 10010 are ever addressed; no signature access exists
   task automatic put(input logic [16:0] a);
      @(posedge ref_clk);
      strb <= 3'h7;
      en <= 1'b1;
      a16 <= a[16];
      pmc <= 1'b1;
      drv <= a[15:8];
      @(posedge ref_clk);
      pmc <= 1'b0;
      drv <= a[7:0];
   endtask : put
   task automatic pulse(input logic [7:0] d);
      @(posedge ref_clk);
      drv <= d;
      en <= 1'b1;
      strb <= 3'h2;
      repeat (PULSE) @(posedge ref_clk);
      strb <= 3'h3;
      pulses++;
   endtask : pulse
   // Release to CE low so the address latch keeps its value
   task automatic rd(output logic [7:0] q);
      @(posedge ref_clk);
      en <= 1'b0;
      // Released bus then reads 00, a byte that no read here expects
      drv <= 8'hFF;
      strb <= 3'h1;
      repeat (3) @(posedge ref_clk);
      #1 q = bus_in;
      strb <= 3'h3;
   endtask : rd
   task automatic prog(input logic [16:0] a, input logic [7:0] d, output logic [7:0] q);
      pulses = 0;
      put(a);
      do begin
         pulse(d);
         rd(q);
      end while (q !== d && pulses < 25);
   endtask : prog
endmodule : prom_prog

// File: otp_program_memory_access_tb.sv
`timescale 1ns/1ps
module otp_program_memory_access_tb;
   logic ref_clk = 1'b0;
   logic rst;
   logic test_vpp;
   logic reset_pin_n;
   logic mql;
   otp_pkg::cpu_rd_t cpu_rd;
   otp_pkg::strobes_t strobes;
   logic pmc, a16, oe, hit, prog_mode, secured;
   logic [7:0] bin, bout, rdata, q;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   always #10 ref_clk = ~ref_clk;
   otp_program_memory_access #(.PULSE_CYCLES(8)) dut (.ref_clk(ref_clk), .rst(rst),
      .test_vpp(test_vpp), .reset_pin_n(reset_pin_n), .mode_qualifier_line(mql),
      .prog_mode_control(pmc), .top_address_bit(a16), .strobes(strobes),
      .shared_port_bus_in(bin), .shared_port_bus_out(bout), .shared_port_bus_oe(oe),
      .cpu_rd(cpu_rd), .cpu_rd_data(rdata), .cpu_rd_hit(hit), .prog_mode(prog_mode),
      .secured(secured));
   prom_prog #(.PULSE(8)) pp (.ref_clk(ref_clk), .bus_out(bout), .bus_oe(oe), .bus_in(bin),
      .strb(strobes), .pmc(pmc), .a16(a16));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk8
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // Whole run needs under 3000 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic cpu(input logic [15:0] a, input logic h, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_rd <= {1'b1, a};
      @(posedge ref_clk);
      cpu_rd <= '0;
      @(posedge ref_clk);
      #1 chk8({7'h0, hit}, {7'h0, h});
      if (h) chk8(rdata, d);
   endtask : cpu
   task automatic t_mode(input logic p);
      @(posedge ref_clk);
      test_vpp <= p;
      reset_pin_n <= !p;
      mql <= p;
      repeat (2) @(posedge ref_clk);
      #1 chk8({7'h0, prog_mode}, {7'h0, p});
   endtask : t_mode
   task automatic t_prog();
      cpu(16'hF810, 1'b0, 8'h00);
      pp.prog(17'h0010, 8'h3C, q);
      chk8(q, 8'h3C);
      pp.prog(17'h07FF, 8'h5A, q);
      chk8(q, 8'h5A);
      pp.prog(17'h0010, 8'hFF, q);
      chk8(q, 8'h3C);
      chk8(8'(pp.pulses), 8'h19);
      pp.put(17'h0800);
      pp.rd(q);
      chk8(q, otp_pkg::ERASED);
      chk8({7'h0, oe}, 8'h01);
      pp.put(17'h10010);
      pp.rd(q);
      chk8(q, otp_pkg::ERASED);
      pp.put(17'h07FF);
      pp.rd(q);
      chk8(q, 8'h5A);
   endtask : t_prog
   task automatic t_run();
      cpu(16'hFFFF, 1'b1, 8'h5A);
      cpu(16'hF810, 1'b1, 8'h3C);
      cpu(16'hF7FF, 1'b0, 8'h00);
   endtask : t_run
   task automatic t_secure();
      chk8({7'h0, secured}, 8'h00);
      pp.put(17'h01101);
      pp.pulse(8'hFE);
      repeat (2) @(posedge ref_clk);
      #1 chk8({7'h0, secured}, 8'h01);
      pp.put(17'h0010);
      pp.rd(q);
      chk8(q, otp_pkg::ERASED);
   endtask : t_secure
   initial begin
      rst <= 1'b1;
      test_vpp <= 1'b0;
      reset_pin_n <= 1'b1;
      mql <= 1'b0;
      cpu_rd <= '0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_mode(1'b1);
      t_prog();
      t_mode(1'b0);
      t_run();
      t_mode(1'b1);
      t_secure();
      print_verdict();
   end
endmodule : otp_program_memory_access_tb
